/* File: mcrb_bank.v */
// Purpose: tx and rx MAC configuration and identification registers
// Assumes: single clock clk_sys, synchronous active-high rst,
//          word-indexed register port with read data one cycle later
// Notes:   build options are parameters; omitted registers read zero
//          the oversize counter halves at 0x410/0x411 are a local choice
//          every register here runs on clk_sys; only the fault pins do not
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_defs.vh"

module mcrb_bank #(
  // build options
  //   DEFICIT_IDLE_EN: 0 drops the idle removal count from the map
  //   TX_STATS_EN:     0 drops the oversize counter, its words read zero
  //   LINK_FAULT_EN:   0 makes the fault status word read zero
  parameter integer     DEFICIT_IDLE_EN = 1,
  parameter integer     TX_STATS_EN     = 1,
  parameter integer     LINK_FAULT_EN   = 0,
  // arbitrary revision value, not tied to any release
  parameter [31:0]      REVISION_ID     = 32'h00010000,
  // arbitrary identifier text, four ASCII characters a word
  parameter [95:0]      TX_IDENT_TEXT   = 96'h6366_6742_616E_6B54_784D_6170
) (
  input  wire                     clk_sys,
  input  wire                     rst,
  // register port
  input  wire [`MCRB_ADDR_W-1:0]  regAddr,
  input  wire [31:0]              regWrData,
  input  wire                     regWr,
  input  wire                     regRd,
  output wire [31:0]              regRdData,
  output wire                     regRdValid,
  // transmit datapath side
  input  wire                     txFrameDone,
  input  wire [`MCRB_LIMIT_W-1:0] txFrameLen,
  output wire [`MCRB_IDLE_W-1:0]  idleRemovalCount,
  output wire [`MCRB_LIMIT_W-1:0] txFrameLimit,
  output wire                     txOversizeEvent,
  // receive fault state, from the link side
  input  wire                     rxLocalFault,
  input  wire                     rxRemoteFault
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  // full 16-bit compares, so no alias of the map ever answers
  //
  // word map (index: contents)
  //   0x400 tx revision word, read-only
  //   0x401 tx scratch word, read/write
  //   0x402 identifier, first four characters, read-only
  //   0x403 identifier, next four characters, read-only
  //   0x404 identifier, final four characters, read-only
  //   0x406 idle removal count, read/write, only with the deficit counter
  //   0x407 tx frame length limit, read/write
  //   0x410 oversize count, low half, read-only
  //   0x411 oversize count, high half frozen by the low read, read-only
  //   0x500 rx revision word, read-only
  //   0x501 rx scratch word, read/write
  //   0x508 fault status, read-only, only with the fault build
  //   anything else reads zero and ignores writes

  wire hitTxRev;
  wire hitTxScratch;
  wire hitIdentFirst;
  wire hitIdentNext;
  wire hitIdentFinal;
  wire hitIdle;
  wire hitLimit;
  wire hitOverLo;
  wire hitOverHi;
  wire hitRxRev;
  wire hitRxScratch;
  wire hitFault;

  assign hitTxRev      = (regAddr == `MCRB_TX_REVISION);
  assign hitTxScratch  = (regAddr == `MCRB_TX_SCRATCH);
  assign hitIdentFirst = (regAddr == `MCRB_TX_IDENT_FIRST);
  assign hitIdentNext  = (regAddr == `MCRB_TX_IDENT_NEXT);
  assign hitIdentFinal = (regAddr == `MCRB_TX_IDENT_FINAL);
  assign hitIdle       = (regAddr == `MCRB_IDLE_REMOVAL);
  assign hitLimit      = (regAddr == `MCRB_TX_FRAME_LIMIT);
  assign hitOverLo     = (regAddr == `MCRB_TX_OVERSIZE_LO);
  assign hitOverHi     = (regAddr == `MCRB_TX_OVERSIZE_HI);
  assign hitRxRev      = (regAddr == `MCRB_RX_REVISION);
  assign hitRxScratch  = (regAddr == `MCRB_RX_SCRATCH);
  assign hitFault      = (regAddr == `MCRB_RX_FAULT_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // write strobes
  // read-only words get no strobe at all, so writes to them vanish
  // the fault status word and the counter words are read-only as well
  // narrow fields take only the low bits of the write data

  wire wrTxScratch;
  wire wrRxScratch;
  wire wrIdle;
  wire wrLimit;

  assign wrTxScratch = regWr && hitTxScratch;
  assign wrRxScratch = regWr && hitRxScratch;
  assign wrIdle      = regWr && hitIdle && (DEFICIT_IDLE_EN != 0);
  assign wrLimit     = regWr && hitLimit;

  ////////////////////////////////////////////////////////////////////////////
  // scratch words, no effect on the datapath
  // nothing downstream reads them; they let software prove the port works

  wire [31:0] txScratch;
  wire [31:0] rxScratch;

  mcrb_cfg_reg #(
    .WIDTH   (32),
    .RST_VAL (`MCRB_SCRATCH_RST)
  ) u_tx_scratch (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wrEn    (wrTxScratch),
    .wrData  (regWrData),
    .value   (txScratch)
  );

  mcrb_cfg_reg #(
    .WIDTH   (32),
    .RST_VAL (`MCRB_SCRATCH_RST)
  ) u_rx_scratch (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wrEn    (wrRxScratch),
    .wrData  (regWrData),
    .value   (rxScratch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // idle removal count
  // any 8-bit value is taken as is; values above the default give the
  // datapath extra removal for clock compensation
  // no range check: software owns the choice of count

  wire [`MCRB_IDLE_W-1:0] idleCount;

  generate
    if (DEFICIT_IDLE_EN != 0) begin : g_idle
      mcrb_cfg_reg #(
        .WIDTH   (`MCRB_IDLE_W),
        .RST_VAL (`MCRB_IDLE_RST)
      ) u_idle (
        .clk_sys (clk_sys),
        .rst     (rst),
        .wrEn    (wrIdle),
        .wrData  (regWrData[`MCRB_IDLE_W-1:0]),
        .value   (idleCount)
      );
    end else begin : g_no_idle
      // no deficit counter: the datapath never looks at this count
      assign idleCount = {`MCRB_IDLE_W{1'b0}};
    end
  endgenerate

  assign idleRemovalCount = idleCount;

  ////////////////////////////////////////////////////////////////////////////
  // transmit frame length limit
  // a write and a frame ending on one edge compare against the old limit;
  // the new limit applies from the next frame on

  wire [`MCRB_LIMIT_W-1:0] frameLimit;

  mcrb_cfg_reg #(
    .WIDTH   (`MCRB_LIMIT_W),
    .RST_VAL (`MCRB_LIMIT_RST)
  ) u_limit (
    .clk_sys (clk_sys),
    .rst     (rst),
    .wrEn    (wrLimit),
    .wrData  (regWrData[`MCRB_LIMIT_W-1:0]),
    .value   (frameLimit)
  );

  assign txFrameLimit = frameLimit;

  ////////////////////////////////////////////////////////////////////////////
  // transmit oversize statistics
  // without the stats build the counter words read zero

  wire [`MCRB_CNT_W-1:0] overCount;
  wire                   overPulse;

  generate
    if (TX_STATS_EN != 0) begin : g_stats
      mcrb_oversize_cnt u_oversize (
        .clk_sys       (clk_sys),
        .rst           (rst),
        .frameDone     (txFrameDone),
        .frameLen      (txFrameLen),
        .frameLimit    (frameLimit),
        .count         (overCount),
        .oversizePulse (overPulse)
      );
    end else begin : g_no_stats
      assign overCount = {`MCRB_CNT_W{1'b0}};
      assign overPulse = 1'b0;
    end
  endgenerate

  assign txOversizeEvent = overPulse;

  // reading the low word freezes the high word, so a carry between the
  // two reads cannot tear the 64-bit value
  // limitation: a high read with no low read before it returns the stale
  // frozen half, zero after reset
  reg  [31:0] overHiHold_reg;
  wire [31:0] overHiHold_next;

  assign overHiHold_next = (regRd && hitOverLo) ? overCount[63:32] : overHiHold_reg;

  always @(posedge clk_sys) begin
    if (rst) begin
      overHiHold_reg <= 32'h00000000;
    end else begin
      overHiHold_reg <= overHiHold_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fault status inputs, asynchronous to clk_sys
  // only the second flop is read; the first may still be settling
  // bit 0 local, bit 1 remote; the remaining bits read zero

  reg  [1:0] faultMeta_reg;
  reg  [1:0] faultSync_reg;
  wire [1:0] faultState;

  always @(posedge clk_sys) begin
    if (rst) begin
      faultMeta_reg <= 2'h0;
      faultSync_reg <= 2'h0;
    end else begin
      faultMeta_reg <= {rxRemoteFault, rxLocalFault};
      faultSync_reg <= faultMeta_reg;
    end
  end

  // without the fault build the word stays zero
  assign faultState = (LINK_FAULT_EN != 0) ? faultSync_reg : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer
  // one priority chain; at most one hit is ever true, so order is free

  reg [31:0] rdData_next;

  always @* begin
    rdData_next = 32'h00000000;
    if (hitTxRev || hitRxRev) begin
      rdData_next = REVISION_ID;
    end else if (hitTxScratch) begin
      rdData_next = txScratch;
    end else if (hitRxScratch) begin
      rdData_next = rxScratch;
    end else if (hitIdentFirst) begin
      rdData_next = TX_IDENT_TEXT[95:64];
    end else if (hitIdentNext) begin
      rdData_next = TX_IDENT_TEXT[63:32];
    end else if (hitIdentFinal) begin
      rdData_next = TX_IDENT_TEXT[31:0];
    end else if (hitIdle) begin
      rdData_next = {24'h000000, idleCount};
    end else if (hitLimit) begin
      rdData_next = {16'h0000, frameLimit};
    end else if (hitOverLo) begin
      rdData_next = overCount[31:0];
    end else if (hitOverHi) begin
      rdData_next = overHiHold_reg;
    end else if (hitFault && (LINK_FAULT_EN != 0)) begin
      rdData_next[`MCRB_FAULT_LOCAL_BIT]  = faultState[0];
      rdData_next[`MCRB_FAULT_REMOTE_BIT] = faultState[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data stands only in the cycle after the strobe
  // zero outside that cycle, so several banks may share one OR-ed return

  reg [31:0] rdData_reg;
  reg        rdValid_reg;

  always @(posedge clk_sys) begin
    if (rst) begin
      rdData_reg  <= 32'h00000000;
      rdValid_reg <= 1'b0;
    end else begin
      rdValid_reg <= regRd;
      if (regRd) begin
        rdData_reg <= rdData_next;
      end else begin
        rdData_reg <= 32'h00000000;
      end
    end
  end

  assign regRdData  = rdData_reg;
  assign regRdValid = rdValid_reg;

endmodule // mcrb_bank

`default_nettype wire

/* File: mcrb_defs.vh */
// Purpose: constants for the MAC configuration register bank
// Assumes: word addressed register port, one index per 32-bit register
// Notes:   included by the bank top and the oversize counter; the config field module does not include it
`ifndef MCRB_DEFS_VH
`define MCRB_DEFS_VH

// register word indices
`define MCRB_ADDR_W            16
`define MCRB_TX_REVISION       16'h0400
`define MCRB_TX_SCRATCH        16'h0401
`define MCRB_TX_IDENT_FIRST    16'h0402
`define MCRB_TX_IDENT_NEXT     16'h0403
`define MCRB_TX_IDENT_FINAL    16'h0404
`define MCRB_IDLE_REMOVAL      16'h0406
`define MCRB_TX_FRAME_LIMIT    16'h0407
`define MCRB_TX_OVERSIZE_LO    16'h0410
`define MCRB_TX_OVERSIZE_HI    16'h0411
`define MCRB_RX_REVISION       16'h0500
`define MCRB_RX_SCRATCH        16'h0501
`define MCRB_RX_FAULT_STATUS   16'h0508

// field widths
`define MCRB_IDLE_W            8
`define MCRB_LIMIT_W           16
`define MCRB_CNT_W             64

// reset values
`define MCRB_SCRATCH_RST       32'h00000000
`define MCRB_IDLE_RST          8'h04
`define MCRB_LIMIT_RST         16'h2580

// fault status field positions
`define MCRB_FAULT_LOCAL_BIT   0
`define MCRB_FAULT_REMOTE_BIT  1

`endif

/* File: mcrb_cfg_reg.v */
// Purpose: one read/write configuration field with synchronous reset
// Assumes: write strobe already qualified by the address decode
// Notes:   used for scratch words, idle count and frame limit
`timescale 1ns/1ps
`default_nettype none

module mcrb_cfg_reg #(
  parameter integer WIDTH     = 32,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input  wire             clk_sys,
  input  wire             rst,
  input  wire             wrEn,
  input  wire [WIDTH-1:0] wrData,
  output wire [WIDTH-1:0] value
);

  reg  [WIDTH-1:0] value_reg;
  wire [WIDTH-1:0] value_next;

  assign value_next = wrEn ? wrData : value_reg;

  always @(posedge clk_sys) begin
    if (rst) begin
      value_reg <= RST_VAL;
    end else begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule // mcrb_cfg_reg

`default_nettype wire

/* File: mcrb_oversize_cnt.v */
// Purpose: counts transmitted frames longer than the programmed limit
// Assumes: frameDone is a one-cycle pulse with frameLen valid beside it
// Notes:   counter wraps at 2^64, which no real link reaches
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_defs.vh"

module mcrb_oversize_cnt (
  input  wire                      clk_sys,
  input  wire                      rst,
  input  wire                      frameDone,
  input  wire [`MCRB_LIMIT_W-1:0]  frameLen,
  input  wire [`MCRB_LIMIT_W-1:0]  frameLimit,
  output wire [`MCRB_CNT_W-1:0]    count,
  output wire                      oversizePulse
);

  reg  [`MCRB_CNT_W-1:0] count_reg;
  reg                    pulse_reg;
  wire                   isOver;

  // strictly greater: a frame equal to the limit is legal
  assign isOver = frameDone && (frameLen > frameLimit);

  always @(posedge clk_sys) begin
    if (rst) begin
      count_reg <= 64'h0000000000000000;
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= isOver;
      if (isOver) begin
        count_reg <= count_reg + 64'h0000000000000001;
      end
    end
  end

  assign count         = count_reg;
  assign oversizePulse = pulse_reg;

endmodule // mcrb_oversize_cnt

`default_nettype wire

/* File: mcrb_bank_assertions.sv */
// Purpose: port checker for mcrb_bank
// Assumes: one clock, synchronous reset
// Notes:   idle and oversize expectations follow the build options from bind
`timescale 1ns/1ps
`default_nettype none

module mcrb_bank_checker #(
  parameter integer DEFICIT_IDLE_EN = 1,
  parameter integer TX_STATS_EN     = 1
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [15:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [31:0] regRdData,
  input wire logic        regRdValid,
  input wire logic        txFrameDone,
  input wire logic [15:0] txFrameLen,
  input wire logic [7:0]  idleRemovalCount,
  input wire logic [15:0] txFrameLimit,
  input wire logic        txOversizeEvent
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire       limWr = regWr && (regAddr == 16'h0407);
  wire       idlWr = regWr && (regAddr == 16'h0406);
  wire       over  = (TX_STATS_EN != 0) && txFrameDone && (txFrameLen > txFrameLimit);
  wire [7:0] wrIdl = (DEFICIT_IDLE_EN != 0) ? regWrData[7:0] : 8'h00;
  wire [7:0] idlRst = (DEFICIT_IDLE_EN != 0) ? 8'h04 : 8'h00;
  wire [15:0] wrLim = regWrData[15:0];
  //////////////////////////////////////////////////////////////////
  a_read_answer: assert property (regRd |=> regRdValid)
    else $error("read not answered");
  a_valid_cause: assert property (regRdValid |-> $past(regRd))
    else $error("read valid without read");
  a_data_quiet: assert property (!regRdValid |-> regRdData == 32'h0)
    else $error("read data not zero");
  a_idle_reset: assert property ($past(rst) |-> idleRemovalCount == idlRst)
    else $error("idle count reset value");
  a_idle_write: assert property (idlWr |=> idleRemovalCount == $past(wrIdl))
    else $error("idle count write");
  a_limit_reset: assert property ($past(rst) |-> txFrameLimit == 16'h2580)
    else $error("limit reset value");
  a_limit_write: assert property (limWr |=> txFrameLimit == $past(wrLim))
    else $error("limit write");
  a_limit_hold: assert property (!limWr |=> $stable(txFrameLimit))
    else $error("limit changed");
  a_oversize_hit: assert property (over |=> txOversizeEvent)
    else $error("oversize missed");
  a_oversize_quiet: assert property (!over |=> !txOversizeEvent)
    else $error("spurious oversize");
  c_read: cover property (regRd ##1 regRdValid);
  c_over: cover property (over ##1 txOversizeEvent);
  c_lim: cover property (limWr ##1 txFrameLimit != 16'h2580);
endmodule // mcrb_bank_checker

bind mcrb_bank mcrb_bank_checker #(.DEFICIT_IDLE_EN(DEFICIT_IDLE_EN),
  .TX_STATS_EN(TX_STATS_EN)) i_mcrb_bank_checker (
  .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid),
  .txFrameDone(txFrameDone), .txFrameLen(txFrameLen),
  .idleRemovalCount(idleRemovalCount), .txFrameLimit(txFrameLimit),
  .txOversizeEvent(txOversizeEvent));
`default_nettype wire

/* File: testbench.sv */
// Purpose: self-checking bench for mcrb_bank
// Assumes: second instance built without idle count or stats, with fault status
// Notes:   both instances share every input
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam [31:0] REV   = 32'h13572468; // arbitrary value
  localparam [95:0] IDENT = "tbIdTextWord"; // arbitrary text
  logic        clk_sys, rst, regWr, regRd, txFrameDone, rxLocalFault, rxRemoteFault;
  logic        regRdValid, txOversizeEvent, overB;
  logic [15:0] regAddr, txFrameLen, txFrameLimit;
  logic [31:0] regWrData, regRdData, rdB;
  logic [7:0]  idleRemovalCount, idleB;
  int          miscompares, compares, cycles;

  mcrb_bank #(.REVISION_ID(REV), .TX_IDENT_TEXT(IDENT)) i_mcrb_bank (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .regRdValid(regRdValid),
    .txFrameDone(txFrameDone), .txFrameLen(txFrameLen),
    .idleRemovalCount(idleRemovalCount), .txFrameLimit(txFrameLimit),
    .txOversizeEvent(txOversizeEvent), .rxLocalFault(rxLocalFault),
    .rxRemoteFault(rxRemoteFault));
  // other build options, so omitted and optional words are seen both ways
  mcrb_bank #(.DEFICIT_IDLE_EN(0), .TX_STATS_EN(0), .LINK_FAULT_EN(1), .REVISION_ID(REV),
    .TX_IDENT_TEXT(IDENT)) i_mcrb_bank_opt (
    .clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(rdB), .regRdValid(),
    .txFrameDone(txFrameDone), .txFrameLen(txFrameLen),
    .idleRemovalCount(idleB), .txFrameLimit(), .txOversizeEvent(overB),
    .rxLocalFault(rxLocalFault), .rxRemoteFault(rxRemoteFault));
  //////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic results();
    if (miscompares == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      results();
    end
  end

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] eB);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    chk("regRdValid", 1'b1, regRdValid);
    chk("regRdData", e, regRdData);
    chk("rdOpt", eB, rdB);
  endtask

  task automatic frame(input logic [15:0] len, input logic exp);
    @(posedge clk_sys);
    txFrameDone <= 1'b1;
    txFrameLen <= len;
    @(posedge clk_sys);
    txFrameDone <= 1'b0;
    #1;
    chk("txOversizeEvent", exp, txOversizeEvent);
    chk("overOpt", 1'b0, overB);
  endtask

  task automatic t_reset();
    rd(16'h0400, REV, REV);
    rd(16'h0401, 0, 0);
    rd(16'h0402, IDENT[95:64], IDENT[95:64]);
    rd(16'h0403, IDENT[63:32], IDENT[63:32]);
    rd(16'h0404, IDENT[31:0], IDENT[31:0]);
    rd(16'h0406, 32'h04, 0);
    rd(16'h0407, 32'h2580, 32'h2580);
    rd(16'h0500, REV, REV);
    rd(16'h0501, 0, 0);
    rd(16'h0411, 0, 0);
    chk("idleRemovalCount", 8'h04, idleRemovalCount);
  endtask

  task automatic t_regs();
    wr(16'h0401, 32'hA5A50001);
    wr(16'h0501, 32'h5A5A0002);
    wr(16'h0400, 32'hFFFFFFFF);
    wr(16'h0403, 32'hFFFFFFFF);
    wr(16'h0500, 32'hFFFFFFFF);
    wr(16'h0405, 32'hFFFFFFFF);
    wr(16'h0406, 32'hFFFFFFC9);
    chk("idleRemovalCount", 8'hC9, idleRemovalCount);
    chk("idleOpt", 8'h00, idleB);
    rd(16'h0401, 32'hA5A50001, 32'hA5A50001);
    rd(16'h0501, 32'h5A5A0002, 32'h5A5A0002);
    rd(16'h0400, REV, REV);
    rd(16'h0403, IDENT[63:32], IDENT[63:32]);
    rd(16'h0500, REV, REV);
    rd(16'h0405, 0, 0);
    rd(16'h0406, 32'hC9, 0);
  endtask

  task automatic t_frames();
    wr(16'h0407, 32'h00010064);
    chk("txFrameLimit", 16'h0064, txFrameLimit);
    frame(16'd100, 1'b0);
    frame(16'd101, 1'b1);
    frame(16'hFFFF, 1'b1);
    frame(16'd0, 1'b0);
    rd(16'h0410, 2, 0);
    rd(16'h0411, 0, 0);
  endtask

  task automatic t_fault();
    rd(16'h0508, 0, 0);
    @(posedge clk_sys);
    rxLocalFault <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(16'h0508, 0, 32'h1);
    @(posedge clk_sys);
    rxRemoteFault <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rd(16'h0508, 0, 32'h3);
  endtask

  task automatic t_rereset();
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(16'h0401, 0, 0);
    rd(16'h0407, 32'h2580, 32'h2580);
    rd(16'h0410, 0, 0);
  endtask

  initial begin
    rst = 1'b1;
    regWr = 1'b0;
    regRd = 1'b0;
    regAddr = 16'h0000;
    regWrData = 32'h0;
    txFrameDone = 1'b0;
    txFrameLen = 16'h0;
    rxLocalFault = 1'b0;
    rxRemoteFault = 1'b0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_frames();
    t_fault();
    t_rereset();
    results();
  end
endmodule // testbench
`default_nettype wire
